// file: pmw_device.sv
// Converter end: periodic timer, event routing, differential conversion, sample FIFO, window comparator
//
// Operation
// - Sample positive minus negative input differentially
// - Timer pulse over event fabric starts conversions
// - 16-bit results against 1.25 V reference
// - Batch samples in FIFO; FIFO and threshold interrupts
// - Hold upper/lower thresholds; interrupt on crossing
// - Sampling and comparing run during host deep sleep
// - Host low-passes samples with first-order IIR
// - Host writes window centred on filter output
// - Host keeps offset at least five RMS noise
// - Host may suspend detection during known disturbances
// - Host defaults: 32 Hz sampling, 1024 LSB window
//
// Local design decisions: the register addresses and the Wishbone register port.
`include "pmw_map.svh"

module pmw_device
    import pmw_pkg::*;
#(
    parameter int DEPTH = `PMW_FIFO_DEPTH,
    parameter int CONV_CYC = `PMW_CONV_CYC
)
(
    input wire logic CORE_CLK_IN, // 20 MHz clock
    input wire logic RESETN_IN, // Asynchronous reset, active low
    pmw_link_if.dev link, // Link to the host end
    input wire logic [15:0] AFE_POS_IN, // Positive input code
    input wire logic [15:0] AFE_NEG_IN, // Negative input code
    output logic MOTION_OUT, // Motion flag
    output logic OVERRUN_OUT, // Missed trigger flag
    output pmw_sample_t LAST_SAMPLE_OUT // Latest conversion result
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam int KW = (CONV_CYC > 1) ? $clog2(CONV_CYC) : 1;
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    // Low-power periodic timer
    logic [`PMW_PERIOD_W-1:0] tmr_q;
    logic [`PMW_PERIOD_W-1:0] tmr_d;
    logic tick;

    always_comb
    begin
        tmr_d = tmr_q + 20'h1;
        tick = 1'b0;
        if (tmr_q >= link.period_cyc - 20'h1)
        begin
            tmr_d = 20'h0;
            tick = 1'b1;
        end
        if (!link.sample_en)
        begin
            tmr_d = 20'h0;
            tick = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            tmr_q <= 20'h0;
        else
            tmr_q <= tmr_d;
    end

    // Event routing fabric: one stage carrying the timer pulse to the converter
    logic evt_q;
    logic evt_d;

    always_comb
    begin
        evt_d = tick;
    end

    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            evt_q <= 1'b0;
        else
            evt_q <= evt_d;
    end

    // Converter
    pmw_dev_state_t st_q;
    pmw_dev_state_t st_d;
    logic [KW-1:0] cnt_q;
    logic [KW-1:0] cnt_d;
    logic [15:0] pos_q;
    logic [15:0] pos_d;
    logic [15:0] neg_q;
    logic [15:0] neg_d;
    pmw_sample_t res_q;
    pmw_sample_t res_d;
    pmw_sample_t upper_q;
    pmw_sample_t upper_d;
    pmw_sample_t lower_q;
    pmw_sample_t lower_d;
    logic motion_q;
    logic motion_d;
    logic ovr_q;
    logic ovr_d;
    logic signed [16:0] diff;
    pmw_sample_t conv;
    logic push;
    logic [CW-1:0] cnt_fifo_q;

    always_comb
    begin
        diff = $signed({1'b0, pos_q}) - $signed({1'b0, neg_q});
        if (diff > 17'sh07fff)
            conv = 16'sh7fff;
        else if (diff < -17'sh08000)
            conv = 16'sh8000;
        else
            conv = diff[15:0];
    end

    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        pos_d = pos_q;
        neg_d = neg_q;
        res_d = res_q;
        upper_d = upper_q;
        lower_d = lower_q;
        motion_d = motion_q;
        ovr_d = ovr_q;
        push = 1'b0;
        if (link.irq_ack)
        begin
            motion_d = 1'b0;
            ovr_d = 1'b0;
        end
        if (link.thr_we)
        begin
            upper_d = link.thr_upper;
            lower_d = link.thr_lower;
        end
        case (st_q)
            PMW_DEV_IDLE:
            begin
                if (evt_q)
                begin
                    pos_d = AFE_POS_IN;
                    neg_d = AFE_NEG_IN;
                    cnt_d = KW'(CONV_CYC - 1);
                    st_d = PMW_DEV_CONV;
                end
            end
            PMW_DEV_CONV:
            begin
                if (cnt_q == '0)
                begin
                    res_d = conv;
                    // Compare at once so a crossing is flagged even while the FIFO is full
                    if (link.detect_en && (conv > upper_q || conv < lower_q))
                        motion_d = 1'b1;
                    st_d = PMW_DEV_PUSH;
                end
                else
                    cnt_d = cnt_q - KW'(1);
            end
            PMW_DEV_PUSH:
            begin
                // Stalls here while the FIFO is full
                if (cnt_fifo_q != FULL_CNT)
                begin
                    push = 1'b1;
                    st_d = PMW_DEV_IDLE;
                end
            end
            default:
                st_d = PMW_DEV_IDLE;
        endcase
        if (evt_q && st_q != PMW_DEV_IDLE)
            ovr_d = 1'b1;
    end

    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            st_q <= PMW_DEV_IDLE;
            cnt_q <= '0;
            pos_q <= 16'h0;
            neg_q <= 16'h0;
            res_q <= 16'h0;
            upper_q <= `PMW_UPPER_RST;
            lower_q <= `PMW_LOWER_RST;
            motion_q <= 1'b0;
            ovr_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            pos_q <= pos_d;
            neg_q <= neg_d;
            res_q <= res_d;
            upper_q <= upper_d;
            lower_q <= lower_d;
            motion_q <= motion_d;
            ovr_q <= ovr_d;
        end
    end

    // Sample FIFO
    pmw_sample_t mem_q [DEPTH];
    pmw_sample_t mem_d [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] wr_d;
    logic [PW-1:0] rd_q;
    logic [PW-1:0] rd_d;
    logic [CW-1:0] cnt_fifo_d;
    logic pop;

    always_comb
    begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_fifo_d = cnt_fifo_q;
        pop = link.s_valid && link.s_ready;
        if (push)
        begin
            mem_d[wr_q] = res_q;
            wr_d = (wr_q == LAST_PTR) ? '0 : wr_q + PW'(1);
        end
        if (pop)
            rd_d = (rd_q == LAST_PTR) ? '0 : rd_q + PW'(1);
        if (push && !pop)
            cnt_fifo_d = cnt_fifo_q + CW'(1);
        else if (pop && !push)
            cnt_fifo_d = cnt_fifo_q - CW'(1);
    end

    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem_q[i] <= 16'h0;
            wr_q <= '0;
            rd_q <= '0;
            cnt_fifo_q <= '0;
        end
        else
        begin
            mem_q <= mem_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_fifo_q <= cnt_fifo_d;
        end
    end

    assign link.s_valid = (cnt_fifo_q != '0);
    assign link.s_data = mem_q[rd_q];
    assign link.fifo_irq = (cnt_fifo_q == FULL_CNT);
    assign link.motion_irq = motion_q;
    assign link.overrun = ovr_q;
    assign MOTION_OUT = motion_q;
    assign OVERRUN_OUT = ovr_q;
    assign LAST_SAMPLE_OUT = res_q;

endmodule

// file: pmw_host.sv
// Host end: drains samples, runs the IIR low-pass and re-centres the detection window
`include "pmw_map.svh"

module pmw_host
    import pmw_pkg::*;
#(
    parameter logic [19:0] PERIOD = 20'(`PMW_PERIOD_CYC)
)
(
    input wire logic CORE_CLK_IN, // 20 MHz clock
    input wire logic RESETN_IN, // Asynchronous reset, active low
    pmw_link_if.host link, // Link to the converter end
    input wire logic WB_CYC_IN, // Wishbone cycle
    input wire logic WB_STB_IN, // Wishbone strobe
    input wire logic WB_WE_IN, // Wishbone write enable
    input wire logic [4:0] WB_ADR_IN, // Wishbone byte address
    input wire logic [3:0] WB_SEL_IN, // Wishbone byte enables
    input wire logic [31:0] WB_DAT_IN, // Wishbone write data
    output logic [31:0] WB_DAT_OUT, // Wishbone read data
    output logic WB_ACK_OUT, // Wishbone acknowledge
    output logic WAKE_OUT, // Host is awake
    output logic MOTION_OUT // Sticky motion status
);

    // Register file
    logic [2:0] ctrl_q;
    logic [2:0] ctrl_d;
    logic [15:0] half_q;
    logic [15:0] half_d;
    logic [19:0] period_q;
    logic [19:0] period_d;
    logic [3:0] shift_q;
    logic [3:0] shift_d;
    logic ack_q;
    logic ack_d;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic mot_q;
    logic mot_d;
    logic signed [23:0] y_q;
    logic [31:0] wd;
    logic req;
    logic ack_evt;
    pmw_host_state_t st_q;

    always_comb
    begin
        for (int b = 0; b < 4; b++)
            wd[8*b +: 8] = WB_SEL_IN[b] ? WB_DAT_IN[8*b +: 8] : 8'h0;
        req = WB_CYC_IN && WB_STB_IN && !ack_q;
        ctrl_d = ctrl_q;
        half_d = half_q;
        period_d = period_q;
        shift_d = shift_q;
        ack_d = req;
        rdat_d = rdat_q;
        mot_d = mot_q;
        if (req && WB_WE_IN)
        begin
            case (WB_ADR_IN)
                `PMW_REG_CTRL: if (WB_SEL_IN[0]) ctrl_d = wd[2:0];
                `PMW_REG_HALF: if (WB_SEL_IN[1:0] == 2'h3) half_d = wd[15:0];
                `PMW_REG_PERIOD: if (WB_SEL_IN[2:0] == 3'h7) period_d = wd[19:0];
                `PMW_REG_SHIFT: if (WB_SEL_IN[0]) shift_d = wd[3:0];
                `PMW_REG_STATUS: if (wd[`PMW_STAT_MOTION]) mot_d = 1'b0;
                default: ;
            endcase
        end
        // Set wins over a software clear in the same cycle
        if (ack_evt && link.motion_irq)
            mot_d = 1'b1;
        if (req && !WB_WE_IN)
        begin
            case (WB_ADR_IN)
                `PMW_REG_CTRL: rdat_d = {29'h0, ctrl_q};
                `PMW_REG_HALF: rdat_d = {16'h0, half_q};
                `PMW_REG_PERIOD: rdat_d = {12'h0, period_q};
                `PMW_REG_SHIFT: rdat_d = {28'h0, shift_q};
                `PMW_REG_STATUS: rdat_d = {29'h0, link.overrun, (st_q != PMW_HOST_SLEEP), mot_q};
                `PMW_REG_CENTRE: rdat_d = {{16{y_q[23]}}, y_q[23:8]};
                default: rdat_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            ctrl_q <= `PMW_CTRL_RST;
            half_q <= 16'(`PMW_HALF_WIN);
            period_q <= PERIOD;
            shift_q <= 4'(`PMW_IIR_SHIFT);
            ack_q <= 1'b0;
            rdat_q <= 32'h0;
            mot_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            half_q <= half_d;
            period_q <= period_d;
            shift_q <= shift_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            mot_q <= mot_d;
        end
    end

    // Firmware sequencer and filter
    pmw_host_state_t st_d;
    logic signed [23:0] y_d;
    logic signed [24:0] err;
    logic signed [17:0] up_s;
    logic signed [17:0] lo_s;
    pmw_sample_t up_q;
    pmw_sample_t up_d;
    pmw_sample_t lo_q;
    pmw_sample_t lo_d;

    always_comb
    begin
        st_d = st_q;
        y_d = y_q;
        err = $signed({link.s_data[15], link.s_data, 8'h0}) - $signed({y_q[23], y_q});
        up_s = $signed({{2{y_q[23]}}, y_q[23:8]}) + $signed({2'b00, half_q});
        lo_s = $signed({{2{y_q[23]}}, y_q[23:8]}) - $signed({2'b00, half_q});
        up_d = (up_s > 18'sh07fff) ? 16'sh7fff : up_s[15:0];
        lo_d = (lo_s < -18'sh08000) ? 16'sh8000 : lo_s[15:0];
        ack_evt = 1'b0;
        case (st_q)
            PMW_HOST_SLEEP:
            begin
                // Woken by a full batch or a detection
                if (link.fifo_irq || link.motion_irq)
                    st_d = PMW_HOST_DRAIN;
            end
            PMW_HOST_DRAIN:
            begin
                if (link.s_valid)
                    y_d = y_q + 24'(err >>> shift_q);
                else
                    st_d = PMW_HOST_UPDATE;
            end
            PMW_HOST_UPDATE:
            begin
                ack_evt = 1'b1;
                st_d = PMW_HOST_SLEEP;
            end
            default:
                st_d = PMW_HOST_SLEEP;
        endcase
    end

    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            st_q <= PMW_HOST_SLEEP;
            y_q <= 24'h0;
            up_q <= `PMW_UPPER_RST;
            lo_q <= `PMW_LOWER_RST;
        end
        else
        begin
            st_q <= st_d;
            y_q <= y_d;
            up_q <= up_d;
            lo_q <= lo_d;
        end
    end

    assign link.s_ready = (st_q == PMW_HOST_DRAIN);
    assign link.thr_we = (st_q == PMW_HOST_UPDATE);
    assign link.irq_ack = ack_evt;
    assign link.thr_upper = up_q;
    assign link.thr_lower = lo_q;
    assign link.sample_en = ctrl_q[`PMW_CTRL_SAMPLE];
    assign link.detect_en = ctrl_q[`PMW_CTRL_DETECT] && !ctrl_q[`PMW_CTRL_SUSPEND];
    assign link.period_cyc = period_q;
    assign WB_ACK_OUT = ack_q;
    assign WB_DAT_OUT = rdat_q;
    assign WAKE_OUT = (st_q != PMW_HOST_SLEEP);
    assign MOTION_OUT = mot_q;

endmodule

// file: pmw_link_checker.sv
// Concurrent checks on the link between the converter end and the host end
module pmw_link_checker
    import pmw_pkg::*;
(
    input wire logic CORE_CLK_IN, // 20 MHz clock
    input wire logic RESETN_IN, // Asynchronous reset, active low
    input wire logic s_valid, // FIFO not empty
    input wire logic s_ready, // Host draining
    input wire pmw_sample_t s_data, // FIFO head
    input wire logic fifo_irq, // Batch ready
    input wire logic motion_irq, // Sticky motion
    input wire logic irq_ack, // Clears motion and overrun
    input wire logic thr_we, // Threshold load
    input wire pmw_sample_t thr_upper, // Upper threshold
    input wire pmw_sample_t thr_lower, // Lower threshold
    input wire logic detect_en // Comparison active
);
    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (!RESETN_IN);

    sequence s_drain_end;
        $fell(s_ready);
    endsequence
    sequence s_update;
        thr_we && irq_ack;
    endsequence

    property p_stream_hold;
        s_valid && !s_ready |=> s_valid && $stable(s_data);
    endproperty
    property p_full_valid;
        fifo_irq |-> s_valid;
    endproperty
    property p_batch_wakes;
        fifo_irq && !s_ready |-> ##[1:3] s_ready;
    endproperty
    property p_drain_update;
        s_drain_end |-> s_update;
    endproperty
    property p_update_pulse;
        s_update |=> !thr_we && !irq_ack;
    endproperty
    property p_window_sym;
        thr_we |-> thr_upper > thr_lower && thr_upper[0] == thr_lower[0];
    endproperty
    property p_motion_sticky;
        motion_irq && !irq_ack |=> motion_irq;
    endproperty
    property p_motion_wakes;
        $rose(motion_irq) |-> ##[1:4] (s_ready || thr_we);
    endproperty
    property p_quiet_off;
        !detect_en && !motion_irq |=> !motion_irq;
    endproperty

    a_stream_hold: assert property (p_stream_hold) else $error("sample dropped while stalled");
    a_full_valid: assert property (p_full_valid) else $error("batch flag without data");
    a_batch_wakes: assert property (p_batch_wakes) else $error("host not woken by batch");
    a_drain_update: assert property (p_drain_update) else $error("no window reload after drain");
    a_update_pulse: assert property (p_update_pulse) else $error("reload pulse too long");
    a_window_sym: assert property (p_window_sym) else $error("window not symmetric");
    a_motion_sticky: assert property (p_motion_sticky) else $error("motion lost before ack");
    a_motion_wakes: assert property (p_motion_wakes) else $error("host not woken by motion");
    a_quiet_off: assert property (p_quiet_off) else $error("motion while detection off");

    c_motion: cover property ($rose(motion_irq));
    c_stall: cover property (fifo_irq && !s_ready);
endmodule

// file: pmw_link_if.sv
// Link between the converter end and the host end
interface pmw_link_if;
    import pmw_pkg::*;
    logic s_valid;
    logic s_ready;
    pmw_sample_t s_data;
    logic fifo_irq;
    logic motion_irq;
    logic overrun;
    logic irq_ack;
    logic thr_we;
    pmw_sample_t thr_upper;
    pmw_sample_t thr_lower;
    logic sample_en;
    logic detect_en;
    logic [19:0] period_cyc;

    modport dev (
        output s_valid, s_data, fifo_irq, motion_irq, overrun,
        input s_ready, irq_ack, thr_we, thr_upper, thr_lower, sample_en, detect_en, period_cyc
    );
    modport host (
        input s_valid, s_data, fifo_irq, motion_irq, overrun,
        output s_ready, irq_ack, thr_we, thr_upper, thr_lower, sample_en, detect_en, period_cyc
    );
endinterface

// file: pmw_map.svh
// Offsets, field positions, reset values and timing counts of the PIR motion window detector
`ifndef PMW_MAP_SVH
`define PMW_MAP_SVH

// Converter
`define PMW_RES_BITS 16
`define PMW_REF_MV 1250
`define PMW_LSB_NV 19073
`define PMW_CONV_CYC 4
`define PMW_FIFO_DEPTH 2

// Timing
`define PMW_CLK_HZ 20000000
`define PMW_RATE_HZ 32
`define PMW_PERIOD_CYC (`PMW_CLK_HZ / `PMW_RATE_HZ)
`define PMW_PERIOD_W 20

// Filter and window defaults
`define PMW_CUTOFF_MHZ 500
`define PMW_IIR_SHIFT 3
`define PMW_WIN_SIZE 1024
`define PMW_HALF_WIN (`PMW_WIN_SIZE / 2)
`define PMW_UPPER_RST 16'h7fff
`define PMW_LOWER_RST 16'h8000

// Host register byte offsets
`define PMW_REG_CTRL 5'h00
`define PMW_REG_HALF 5'h04
`define PMW_REG_PERIOD 5'h08
`define PMW_REG_SHIFT 5'h0c
`define PMW_REG_STATUS 5'h10
`define PMW_REG_CENTRE 5'h14

// Field positions
`define PMW_CTRL_SAMPLE 0
`define PMW_CTRL_DETECT 1
`define PMW_CTRL_SUSPEND 2
`define PMW_CTRL_RST 3'h3
`define PMW_STAT_MOTION 0
`define PMW_STAT_AWAKE 1
`define PMW_STAT_OVERRUN 2

`endif

// file: pmw_pkg.sv
// Types shared by both ends of the PIR motion window detector
package pmw_pkg;
    typedef logic signed [15:0] pmw_sample_t;
    typedef enum logic [1:0] {
        PMW_DEV_IDLE = 2'b00,
        PMW_DEV_CONV = 2'b01,
        PMW_DEV_PUSH = 2'b10
    } pmw_dev_state_t;
    typedef enum logic [1:0] {
        PMW_HOST_SLEEP = 2'b00,
        PMW_HOST_DRAIN = 2'b01,
        PMW_HOST_UPDATE = 2'b10
    } pmw_host_state_t;
endpackage

// file: pmw_tb.sv
// Self-checking bench joining both ends of the PIR motion window detector
`include "pmw_map.svh"

module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] S_POS [4] = '{16'h0000, 16'h0100, 16'hffff, 16'h1100};
    localparam logic [15:0] S_NEG [4] = '{16'hffff, 16'h0300, 16'h0000, 16'h1000};
    localparam logic [15:0] S_EXP [4] = '{16'h8000, 16'hfe00, 16'h7fff, 16'h0100};
    localparam logic [15:0] W_HALF [5] = '{16'h0200, 16'h0200, 16'h0040, 16'h0200, 16'h0200};
    localparam logic [15:0] W_DIFF [5] = '{16'h0200, 16'h0201, 16'h0041, 16'hfe01, 16'hfdfe};
    localparam logic W_EXP [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [4:0] wb_adr = 5'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat_w = 32'h0;
    logic [31:0] wb_dat_r;
    logic wb_ack;
    logic host_wake;
    logic host_motion;
    logic dev_motion;
    logic dev_overrun;
    logic [15:0] last_sample;
    logic [15:0] afe_pos = 16'h1000;
    logic [15:0] afe_neg = 16'h1000;
    logic [31:0] rd;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    logic ovr_seen = 1'b0;

    always #25 core_clk = ~core_clk;

    pmw_link_if i_pmw_link_if();

    pmw_device #(.DEPTH(2), .CONV_CYC(4)) i_pmw_device (
        .CORE_CLK_IN(core_clk),
        .RESETN_IN(resetn),
        .link(i_pmw_link_if),
        .AFE_POS_IN(afe_pos),
        .AFE_NEG_IN(afe_neg),
        .MOTION_OUT(dev_motion),
        .OVERRUN_OUT(dev_overrun),
        .LAST_SAMPLE_OUT(last_sample)
    );

    pmw_host #(.PERIOD(20'd50)) i_pmw_host (
        .CORE_CLK_IN(core_clk),
        .RESETN_IN(resetn),
        .link(i_pmw_link_if),
        .WB_CYC_IN(wb_cyc),
        .WB_STB_IN(wb_stb),
        .WB_WE_IN(wb_we),
        .WB_ADR_IN(wb_adr),
        .WB_SEL_IN(wb_sel),
        .WB_DAT_IN(wb_dat_w),
        .WB_DAT_OUT(wb_dat_r),
        .WB_ACK_OUT(wb_ack),
        .WAKE_OUT(host_wake),
        .MOTION_OUT(host_motion)
    );

    pmw_link_checker i_pmw_link_checker (
        .CORE_CLK_IN(core_clk),
        .RESETN_IN(resetn),
        .s_valid(i_pmw_link_if.s_valid),
        .s_ready(i_pmw_link_if.s_ready),
        .s_data(i_pmw_link_if.s_data),
        .fifo_irq(i_pmw_link_if.fifo_irq),
        .motion_irq(i_pmw_link_if.motion_irq),
        .irq_ack(i_pmw_link_if.irq_ack),
        .thr_we(i_pmw_link_if.thr_we),
        .thr_upper(i_pmw_link_if.thr_upper),
        .thr_lower(i_pmw_link_if.thr_lower),
        .detect_en(i_pmw_link_if.detect_en)
    );

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One classic cycle, held until ack is sampled high
    task automatic wb_cycle(input logic we, input logic [4:0] adr, input logic [31:0] dat);
        @(posedge core_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= 4'hf;
        wb_dat_w <= dat;
        // Ends when ack is sampled high; only the bench timeout ends a hang
        do
            @(posedge core_clk);
        while (wb_ack !== 1'b1);
        rd = wb_dat_r;
        check({31'h0, wb_ack}, 32'h1);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] adr, input logic [31:0] dat);
        wb_cycle(1'b1, adr, dat);
    endtask

    task automatic rdr(input logic [4:0] adr);
        wb_cycle(1'b0, adr, 32'h0);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic set_diff(input logic [15:0] pos, input logic [15:0] neg);
        @(posedge core_clk);
        afe_pos <= pos;
        afe_neg <= neg;
    endtask

    // Sticky record of any overrun seen on the device pin
    always @(posedge core_clk)
    begin
        if (dev_overrun === 1'b1)
            ovr_seen <= 1'b1;
    end

    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end

    initial
    begin
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        rdr(`PMW_REG_CTRL);
        check(rd, 32'h0000_0003);
        rdr(`PMW_REG_HALF);
        check(rd, 32'h0000_0200);
        rdr(`PMW_REG_SHIFT);
        check(rd, 32'h0000_0003);
        rdr(`PMW_REG_PERIOD);
        check(rd, 32'h0000_0032);
        wr(5'h18, 32'hffff_ffff);
        rdr(5'h18);
        check(rd, 32'h0);
        // Differential results and clamping, with detection suspended
        wr(`PMW_REG_CTRL, 32'h7);
        for (int i = 0; i < 4; i++)
        begin
            set_diff(S_POS[i], S_NEG[i]);
            wait_cyc(150);
            check({16'h0, last_sample}, {16'h0, S_EXP[i]});
            check({31'h0, host_motion}, 32'h0);
            check({31'h0, dev_motion}, 32'h0);
        end
        set_diff(16'h1000, 16'h1000);
        wait_cyc(6000);
        rdr(`PMW_REG_CENTRE);
        check(rd, 32'h0);
        wr(`PMW_REG_CTRL, 32'h3);
        // Window edges on both sides, strict compare
        for (int i = 0; i < 5; i++)
        begin
            wr(`PMW_REG_HALF, {16'h0, W_HALF[i]});
            wait_cyc(200);
            set_diff(16'h4000 + W_DIFF[i], 16'h4000);
            wait_cyc(150);
            rdr(`PMW_REG_STATUS);
            check({31'h0, rd[0]}, {31'h0, W_EXP[i]});
            check({31'h0, host_motion}, {31'h0, W_EXP[i]});
            set_diff(16'h4000, 16'h4000);
            wait_cyc(3000);
            wr(`PMW_REG_STATUS, 32'h1);
            rdr(`PMW_REG_STATUS);
            check({31'h0, rd[0]}, 32'h0);
        end
        // Triggers faster than a conversion must raise overrun, and the host clears it
        check({31'h0, ovr_seen}, 32'h0);
        wr(`PMW_REG_PERIOD, 32'h3);
        wait_cyc(100);
        check({31'h0, ovr_seen}, 32'h1);
        wr(`PMW_REG_PERIOD, 32'h32);
        wait_cyc(300);
        rdr(`PMW_REG_STATUS);
        check({30'h0, rd[2], rd[0]}, 32'h0);
        check({31'h0, dev_overrun}, 32'h0);
        // Conversions stop without the timer and resume with it
        wr(`PMW_REG_CTRL, 32'h2);
        wait_cyc(100);
        check({31'h0, host_wake}, 32'h0);
        rdr(`PMW_REG_STATUS);
        check({31'h0, rd[1]}, 32'h0);
        set_diff(16'h4100, 16'h4000);
        wait_cyc(300);
        check({16'h0, last_sample}, 32'h0);
        wr(`PMW_REG_CTRL, 32'h3);
        wait_cyc(150);
        check({16'h0, last_sample}, 32'h0000_0100);
        tally_and_finish();
    end
endmodule
